// *** hw/chg_option_current_regs.sv ***
// Option byte and charge-current setpoint registers behind a serial bus slave
`timescale 1ns/1ps
`default_nettype none
`include "chg_regs.svh"

// Both registers are reached over a two-wire serial bus whose pins are sampled
// on the system clock, so the bus must run far slower than that clock.
// Written bytes are staged and applied at the closing stop or repeated start,
// so a two-byte setpoint never shows a half-written value at the outputs.
// Hardware clears of the setpoint or regulation bit win over a host write.
module chg_option_current_regs
    import chg_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic comparator_trip_i,
    input wire logic comparator_processor_hot_signal_enable_i,
    input wire logic status_read_i,
    input wire logic battery_present_pin_i,
    input wire logic adapter_valid_flag_i,
    input wire logic register_reset_i,
    input wire logic target_voltage_zero_i,
    input wire logic watchdog_expire_i,
    input wire logic auto_input_regulation_off_i,
    input wire logic sense_resistor_large_i,
    output logic comparator_output_pin_o,
    output logic comparator_status_o,
    output logic system_undervoltage_disable_o,
    output logic converter_off_o,
    output logic input_monitor_gain_select_o,
    output logic battery_monitor_gain_select_o,
    output logic linear_precharge_enable_o,
    output logic battery_switch_full_on_o,
    output logic input_regulation_enable_o,
    output logic charging_block_o,
    output logic charge_enable_o,
    output logic [15:0] charging_amperage_target_o,
    output logic [14:0] charge_current_ma_o
);

    chg_state_t s_r; // Registered state
    chg_state_t s_nxt; // Next state

    // Read data for a register pointer
    // Unmapped pointers read as zero
    function automatic logic [7:0] rd_byte(input logic [7:0] p, input chg_state_t s);
        case (p)
            `CHG_OFS_OPTION: rd_byte = s.opt;
            `CHG_OFS_AMP_LO: rd_byte = s.amp[7:0];
            `CHG_OFS_AMP_HI: rd_byte = s.amp[15:8];
            default: rd_byte = 8'h00;
        endcase
    endfunction

    // Decoded conditions, rebuilt every cycle from pins and state
    logic scl_rise; // Clock rising edge
    logic scl_fall; // Clock falling edge
    logic bus_start; // Start or repeated start
    logic bus_stop; // Stop condition
    logic bat_fall; // Battery removed
    logic ac_fall; // Adapter removed
    logic amp_clear; // Any event that zeroes the setpoint
    logic hold_toggle; // Latch enable changed by a host write
    logic [7:0] opt_new; // Option byte after commit
    logic [6:0] amp_code; // Active setpoint code

    // Bus edge and event detection
    // Edges compare the live pin with the copy from the last clock edge
    // Start and stop need SCL high in both samples
    always_comb begin
        scl_rise = scl_i & ~s_r.scl_q;
        scl_fall = ~scl_i & s_r.scl_q;
        bus_start = scl_i & s_r.scl_q & s_r.sda_q & ~sda_i;
        bus_stop = scl_i & s_r.scl_q & ~s_r.sda_q & sda_i;
        bat_fall = s_r.bat_q & ~battery_present_pin_i;
        ac_fall = s_r.ac_q & ~adapter_valid_flag_i;
        // Fault inputs are not wired here, so faults leave the setpoint alone
        amp_clear = bat_fall | ac_fall | register_reset_i | target_voltage_zero_i
                    | watchdog_expire_i;
    end

    // Next-state logic: bus slave, commit, event clears, comparator hold
    always_comb begin
        // Every field keeps its value unless a branch below changes it
        s_nxt = s_r;
        // Pin copies feed the edge detectors on the next cycle
        s_nxt.scl_q = scl_i;
        s_nxt.sda_q = sda_i;
        s_nxt.bat_q = battery_present_pin_i;
        s_nxt.ac_q = adapter_valid_flag_i;
        opt_new = s_r.opt;
        hold_toggle = 1'b0;

        // Serial slave sequencing
        case (s_r.st)
            CHG_IDLE: begin
                // Wait for a start condition
                // Stray clock pulses between transfers are ignored
            end
            CHG_ADDR, CHG_PTR, CHG_WDAT: begin
                // Shift in a byte on rising clock
                // Count reaches eight on the last rise; the byte is judged at the fall
                if (scl_rise) begin
                    s_nxt.sh = {s_r.sh[6:0], sda_i};
                    s_nxt.cnt = s_r.cnt + 4'h1;
                end else if (scl_fall && s_r.cnt == 4'h8) begin
                    s_nxt.cnt = 4'h0;
                    if (s_r.st == CHG_ADDR) begin
                        // Answer only our own address
                        if (s_r.sh[7:1] == `CHG_DEV_ADDR) begin
                            s_nxt.rw = s_r.sh[0];
                            s_nxt.st = CHG_AACK;
                        end else begin
                            s_nxt.st = CHG_IDLE;
                        end
                    end else if (s_r.st == CHG_PTR) begin
                        // Pointer byte sets where the following data bytes land
                        s_nxt.ptr = s_r.sh;
                        s_nxt.st = CHG_WACK;
                    end else begin
                        // Stage data, applied only at end of transaction
                        case (s_r.ptr)
                            `CHG_OFS_OPTION: begin
                                s_nxt.opt_stg = s_r.sh;
                                s_nxt.opt_w = 1'b1;
                            end
                            `CHG_OFS_AMP_LO: begin
                                s_nxt.lo_stg = s_r.sh;
                                s_nxt.lo_w = 1'b1;
                            end
                            `CHG_OFS_AMP_HI: begin
                                s_nxt.hi_stg = s_r.sh;
                                s_nxt.hi_w = 1'b1;
                            end
                            default: begin
                                // Unmapped pointer, byte dropped
                            end
                        endcase
                        s_nxt.ptr = s_r.ptr + 8'h01;
                        s_nxt.st = CHG_WACK;
                    end
                end
            end
            CHG_AACK, CHG_WACK: begin
                // Acknowledge held through one clock pulse
                // The output logic pulls the data line low in these states
                if (scl_fall) begin
                    if (s_r.st == CHG_AACK && s_r.rw) begin
                        s_nxt.sh = rd_byte(s_r.ptr, s_r);
                        s_nxt.st = CHG_RDAT;
                    end else if (s_r.st == CHG_AACK) begin
                        s_nxt.st = CHG_PTR;
                    end else begin
                        s_nxt.st = CHG_WDAT;
                    end
                    s_nxt.cnt = 4'h0;
                end
            end
            CHG_RDAT: begin
                // Shift out a byte on falling clock
                // Ones shift in behind so the line is released after the last bit
                if (scl_fall) begin
                    s_nxt.sh = {s_r.sh[6:0], 1'b1};
                    s_nxt.cnt = s_r.cnt + 4'h1;
                    if (s_r.cnt == 4'h7) begin
                        s_nxt.st = CHG_RACK;
                        s_nxt.ptr = s_r.ptr + 8'h01;
                    end
                end
            end
            CHG_RACK: begin
                // Master acknowledge: continue, or release on a nack
                // The direction flag is reused to hold the master's answer
                if (scl_rise) begin
                    s_nxt.rw = ~sda_i;
                end else if (scl_fall) begin
                    s_nxt.cnt = 4'h0;
                    s_nxt.sh = rd_byte(s_r.ptr, s_r);
                    s_nxt.st = s_r.rw ? CHG_RDAT : CHG_IDLE;
                end
            end
            default: begin
                // An illegal code returns to idle and waits for a start
                s_nxt.st = CHG_IDLE;
            end
        endcase

        // Start and stop override the sequence; both end a write transaction
        // A start in mid-byte drops that byte; earlier staged bytes still apply
        if (bus_start) begin
            s_nxt.st = CHG_ADDR;
            s_nxt.cnt = 4'h0;
        end else if (bus_stop) begin
            s_nxt.st = CHG_IDLE;
        end

        if (bus_start || bus_stop) begin
            // Apply the staged option byte
            if (s_r.opt_w) begin
                opt_new = s_r.opt_stg;
                hold_toggle = s_r.opt_stg[`CHG_OPT_CMP_HOLD] != s_r.opt[`CHG_OPT_CMP_HOLD];
            end
            // Setpoint applied as one value; invalid high bits drop it
            // A byte not written in this transaction keeps its old value
            if ((s_r.lo_w || s_r.hi_w)
                && !(s_r.hi_w && (s_r.hi_stg & `CHG_AMP_HI_BAD) != 8'h00)) begin
                s_nxt.amp[15:8] = s_r.hi_w ? s_r.hi_stg : s_r.amp[15:8];
                // Low six bits are unused and read back as zero
                s_nxt.amp[7:0] = s_r.lo_w ? (s_r.lo_stg & `CHG_AMP_LO_MASK)
                                          : s_r.amp[7:0];
            end
            s_nxt.opt_w = 1'b0;
            s_nxt.lo_w = 1'b0;
            s_nxt.hi_w = 1'b0;
        end

        // Device drops regulation on battery removal when auto-disable is on
        // The host may set the bit again with a later write
        if (auto_input_regulation_off_i && bat_fall) begin
            opt_new[`CHG_OPT_IN_REG] = 1'b0;
        end
        s_nxt.opt = opt_new;

        // Event clears win over a host write in the same cycle
        // Overcurrent and overvoltage faults have no input here on purpose
        if (amp_clear) begin
            s_nxt.amp = `CHG_AMP_RESET;
        end

        // Comparator hold: set on trip while enabled, released by a toggle
        // A trip in the cycle of the release is not held, since that toggle clears bit 7
        s_nxt.cmp_hold = opt_new[`CHG_OPT_CMP_HOLD]
                         & ((s_r.cmp_hold & ~hold_toggle) | comparator_trip_i);
        s_nxt.cmp_pin = ~(comparator_trip_i | s_nxt.cmp_hold);

        // Status sticks until read when latching in the hot profile; set wins
        // Outside that profile the flag simply follows the comparator
        if (opt_new[`CHG_OPT_CMP_HOLD] && comparator_processor_hot_signal_enable_i) begin
            s_nxt.cmp_stat = comparator_trip_i | (s_r.cmp_stat & ~status_read_i);
        end else begin
            s_nxt.cmp_stat = comparator_trip_i;
        end

        // Register reset command restores the option byte, setpoint, staging flags and comparator hold and pin
        // Bus sequencing is left alone so a transfer in flight completes
        if (register_reset_i) begin
            s_nxt.opt = `CHG_OPT_RESET;
            s_nxt.opt_w = 1'b0;
            s_nxt.lo_w = 1'b0;
            s_nxt.hi_w = 1'b0;
            s_nxt.cmp_hold = 1'b0;
            s_nxt.cmp_pin = ~comparator_trip_i;
        end

        // Current in mA from the code, scaled by sense resistor
        // Step is 64 mA with the large resistor, 128 mA with the small one
        amp_code = s_nxt.amp[`CHG_AMP_CODE_HI:`CHG_AMP_CODE_LO];
        s_nxt.ma = sense_resistor_large_i ? 15'({amp_code, 6'h00}) : 15'({amp_code, 7'h00});
    end

    // State register; power-on defaults
    // Bus pin copies reset high like the idle bus, so no false start follows
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '0;
            s_r.st <= CHG_IDLE;
            s_r.scl_q <= 1'b1;
            s_r.sda_q <= 1'b1;
            s_r.opt <= `CHG_OPT_RESET;
            s_r.amp <= `CHG_AMP_RESET;
            s_r.cmp_pin <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs: open-drain data pulls low on ack and on zero read bits
    // Only the pin enable moves; the driven level is always low
    always_comb begin
        sda_o = 1'b0;
        sda_oe_o = (s_r.st == CHG_AACK) || (s_r.st == CHG_WACK)
                   || (s_r.st == CHG_RDAT && !s_r.sh[7]);
        comparator_output_pin_o = s_r.cmp_pin;
        comparator_status_o = s_r.cmp_stat;
        system_undervoltage_disable_o = s_r.opt[`CHG_OPT_UV_DIS];
        converter_off_o = s_r.opt[`CHG_OPT_DISCHARGE];
        input_monitor_gain_select_o = s_r.opt[`CHG_OPT_IN_GAIN];
        battery_monitor_gain_select_o = s_r.opt[`CHG_OPT_BAT_GAIN];
        linear_precharge_enable_o = s_r.opt[`CHG_OPT_LIN_PRE];
        battery_switch_full_on_o = ~s_r.opt[`CHG_OPT_LIN_PRE];
        input_regulation_enable_o = s_r.opt[`CHG_OPT_IN_REG];
        charging_block_o = s_r.opt[`CHG_OPT_BLOCK];
        charge_enable_o = ~s_r.opt[`CHG_OPT_BLOCK] & (s_r.ma != 15'h0000);
        charging_amperage_target_o = s_r.amp;
        charge_current_ma_o = s_r.ma;
    end

endmodule
`default_nettype wire

// *** common/chg_regs.svh ***
// Register offsets, field positions, reset values and bus constants for the charger register bank
// Function
// - Bit 7 latches comparator output when triggered
// - Latched comparator status holds until host reads
// - Toggling bit 7 releases latched comparator pin
// - Bit 6 set disables system undervoltage protection
// - Bit 5 shuts converter off, battery discharges
// - Bit 4 selects input monitor gain 20x/40x
// - Bit 3 selects battery monitor gain 8x/16x
// - Bit 2 set: linear precharge from setpoint
// - Bit 2 clear: battery switch fully on
// - Bit 1 input regulation enable, resets to one
// - Bit 0 inhibits charging when set
// - Small resistor: 0 to 16.256 A, 128 mA
// - Large resistor: 0 to 8.128 A, 64 mA
// - Setpoint is zero after power-on reset
// - Battery removal clears the setpoint
// - Adapter removal clears the setpoint
// - Register reset command restores all defaults; the code leaves comparator status and bus slave state as they are
// - Zero target voltage write clears setpoint
// - Watchdog expiry clears the setpoint
// - Faults leave the setpoint unchanged
// - Auto-disable clears regulation bit on battery removal
// - Large resistor LSB 64 mA, low six unused
`ifndef CHG_REGS_SVH
`define CHG_REGS_SVH

// Register offsets
`define CHG_OFS_OPTION 8'h00
`define CHG_OFS_AMP_LO 8'h02
`define CHG_OFS_AMP_HI 8'h03

// Option byte fields
`define CHG_OPT_CMP_HOLD 7
`define CHG_OPT_UV_DIS 6
`define CHG_OPT_DISCHARGE 5
`define CHG_OPT_IN_GAIN 4
`define CHG_OPT_BAT_GAIN 3
`define CHG_OPT_LIN_PRE 2
`define CHG_OPT_IN_REG 1
`define CHG_OPT_BLOCK 0

// Reset values
`define CHG_OPT_RESET 8'h0E
`define CHG_AMP_RESET 16'h0000

// Setpoint layout: code bits, unused low bits, invalid high bits
`define CHG_AMP_CODE_HI 12
`define CHG_AMP_CODE_LO 6
`define CHG_AMP_LO_MASK 8'hC0
`define CHG_AMP_HI_BAD 8'hE0

// Device bus address, arbitrary value
`define CHG_DEV_ADDR 7'h2A

`endif

// *** common/chg_pkg.sv ***
// Types for the charger option and charge-current register bank
package chg_pkg;

    // Serial bus slave states, one-hot
    typedef enum logic [7:0] {
        CHG_IDLE = 8'h01,
        CHG_ADDR = 8'h02,
        CHG_AACK = 8'h04,
        CHG_PTR = 8'h08,
        CHG_WDAT = 8'h10,
        CHG_WACK = 8'h20,
        CHG_RDAT = 8'h40,
        CHG_RACK = 8'h80
    } chg_bus_state_t;

    // Whole state of the register bank
    typedef struct packed {
        chg_bus_state_t st;
        logic scl_q;
        logic sda_q;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic [7:0] ptr;
        logic [7:0] opt_stg;
        logic [7:0] lo_stg;
        logic [7:0] hi_stg;
        logic opt_w;
        logic lo_w;
        logic hi_w;
        logic [7:0] opt;
        logic [15:0] amp;
        logic bat_q;
        logic ac_q;
        logic cmp_hold;
        logic cmp_stat;
        logic cmp_pin;
        logic [14:0] ma;
    } chg_state_t;

endpackage

// *** verif/chg_host_model.sv ***
// Serial bus host model that programs and reads the charger registers
`timescale 1ns/1ps
`default_nettype none
`include "chg_regs.svh"
module chg_host_model (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    logic [6:0] dev = `CHG_DEV_ADDR; // Target address, moved to probe refusal
    logic addr_ack; // Address byte was acknowledged
    initial begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end
    // Wait n falling clock edges
    task automatic tk(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // One bit: data moves only while SCL is low
    task automatic bx(input logic b, output logic r);
        sda_oe_o = ~b;
        tk(2);
        scl_o = 1'b1;
        tk(2);
        r = sda_i;
        scl_o = 1'b0;
        tk(1);
    endtask
    // Byte plus acknowledge slot, returns what the wire carried
    task automatic by(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bx(d[i], q[i]);
        bx(ak, a);
    endtask
    // Start or repeated start: SDA falls while SCL high
    task automatic st();
        sda_oe_o = 1'b0;
        tk(1);
        scl_o = 1'b1;
        tk(2);
        sda_oe_o = 1'b1;
        tk(2);
        scl_o = 1'b0;
        tk(1);
    endtask
    // Stop: SDA rises while SCL high, then bus idles
    task automatic sp();
        sda_oe_o = 1'b1;
        tk(1);
        scl_o = 1'b1;
        tk(2);
        sda_oe_o = 1'b0;
        tk(3);
    endtask
    // Write n bytes from pointer p, low byte first; the pair is applied together at the stop
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
        logic [7:0] q;
        logic a;
        st();
        by({dev, 1'b0}, 1'b1, q, a);
        addr_ack = ~a;
        by(p, 1'b1, q, a);
        for (int i = 0; i < n; i++) by(d[8*i +: 8], 1'b1, q, a);
        sp();
    endtask
    // Set pointer, repeated start, read n bytes and refuse the last
    task automatic rd(input logic [7:0] p, input int n, output logic [15:0] v);
        logic [7:0] q;
        logic a;
        v = 16'h0000;
        st();
        by({dev, 1'b0}, 1'b1, q, a);
        by(p, 1'b1, q, a);
        st();
        by({dev, 1'b1}, 1'b1, q, a);
        for (int i = 0; i < n; i++) begin
            by(8'hFF, i == n - 1, q, a);
            v[8*i +: 8] = q;
        end
        sp();
    endtask
endmodule
`default_nettype wire

// *** verif/chg_option_current_regs_props.sv ***
// Concurrent checks on the charger register bank ports
`timescale 1ns/1ps
`default_nettype none
module chg_option_current_regs_props (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic comparator_trip_i,
    input wire logic comparator_processor_hot_signal_enable_i,
    input wire logic status_read_i,
    input wire logic battery_present_pin_i,
    input wire logic adapter_valid_flag_i,
    input wire logic register_reset_i,
    input wire logic target_voltage_zero_i,
    input wire logic watchdog_expire_i,
    input wire logic auto_input_regulation_off_i,
    input wire logic sense_resistor_large_i,
    input wire logic comparator_output_pin_o,
    input wire logic comparator_status_o,
    input wire logic system_undervoltage_disable_o,
    input wire logic linear_precharge_enable_o,
    input wire logic battery_switch_full_on_o,
    input wire logic input_regulation_enable_o,
    input wire logic charging_block_o,
    input wire logic charge_enable_o,
    input wire logic [15:0] charging_amperage_target_o,
    input wire logic [14:0] charge_current_ma_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);
    logic [6:0] code; // Active setpoint code bits
    logic [14:0] ma_exp; // Setpoint in mA for the fitted resistor
    assign code = charging_amperage_target_o[12:6];
    assign ma_exp = sense_resistor_large_i ? {2'b00, code, 6'h00} : {1'b0, code, 7'h00};
    chk_switch_mirror:
    assert property (battery_switch_full_on_o != linear_precharge_enable_o) else $error("switch");
    chk_enable_rule:
    assert property (charge_enable_o == (!charging_block_o && code != 7'h00)) else $error("enable");
    chk_ma_scale:
    assert property ($stable(sense_resistor_large_i) |-> charge_current_ma_o == ma_exp)
        else $error("scale");
    chk_unused_zero:
    assert property (charging_amperage_target_o[5:0] == 6'h00) else $error("low");
    chk_bat_clear:
    assert property ($fell(battery_present_pin_i)
        |-> ##[1:2] charging_amperage_target_o == 16'h0000) else $error("battery removal");
    chk_ac_clear:
    assert property ($fell(adapter_valid_flag_i)
        |-> ##[1:2] charging_amperage_target_o == 16'h0000) else $error("adapter removal");
    chk_cmd_clear:
    assert property (target_voltage_zero_i || watchdog_expire_i
        |=> charging_amperage_target_o == 16'h0000) else $error("event clear");
    chk_reg_default:
    assert property (register_reset_i |=> charging_amperage_target_o == 0 && !charging_block_o
        && linear_precharge_enable_o && input_regulation_enable_o && !system_undervoltage_disable_o)
        else $error("register reset");
    chk_trip_pin:
    assert property (comparator_trip_i |=> !comparator_output_pin_o) else $error("trip");
    chk_status_hold:
    assert property (comparator_status_o && comparator_processor_hot_signal_enable_i && !comparator_trip_i
        && !$past(comparator_trip_i) && !comparator_output_pin_o && !status_read_i
        |=> comparator_status_o) else $error("status");
    chk_auto_off:
    assert property ($fell(battery_present_pin_i) && auto_input_regulation_off_i
        |-> ##[1:2] !input_regulation_enable_o) else $error("auto off");
    cover property (register_reset_i);
    cover property (comparator_status_o && !comparator_trip_i && !comparator_output_pin_o);
    cover property (sense_resistor_large_i && code == 7'h7F);
endmodule
bind chg_option_current_regs chg_option_current_regs_props u_props (.*);
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the charger option and charge-current registers
`timescale 1ns/1ps
`default_nettype none
`include "chg_regs.svh"
module tb;
    logic clock_i, reset_n_i, scl_i, h_oe, comparator_trip_i, comparator_processor_hot_signal_enable_i;
    logic status_read_i, battery_present_pin_i, adapter_valid_flag_i, register_reset_i;
    logic target_voltage_zero_i, watchdog_expire_i, auto_input_regulation_off_i;
    logic sense_resistor_large_i, sda_o, sda_oe_o, comparator_output_pin_o, comparator_status_o;
    logic system_undervoltage_disable_o, converter_off_o, input_monitor_gain_select_o;
    logic battery_monitor_gain_select_o, linear_precharge_enable_o, battery_switch_full_on_o;
    logic input_regulation_enable_o, charging_block_o, charge_enable_o;
    logic [15:0] charging_amperage_target_o, v;
    logic [14:0] charge_current_ma_o;
    logic [7:0] pat [2] = '{8'h55, 8'h2A}; // Option bits 0 to 6 each seen both ways
    int n_mismatch = 0;
    int samples_checked = 0;
    wire logic sda_i = ~(h_oe | (sda_oe_o & ~sda_o)); // Open drain with pull-up
    wire logic [6:0] ob = {system_undervoltage_disable_o, converter_off_o,
        input_monitor_gain_select_o, battery_monitor_gain_select_o, linear_precharge_enable_o,
        input_regulation_enable_o, charging_block_o};
    chg_option_current_regs u_chg_option_current_regs (.*);
    chg_host_model u_chg_host_model (.clock_i(clock_i), .sda_i(sda_i), .scl_o(scl_i),
        .sda_oe_o(h_oe));
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    // Compare one result and count it
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Wait n falling edges
    task automatic w(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    // Raise one clearing event: removals as edges, commands as pulses
    task automatic ev(input int k);
        w(1);
        case (k)
            0: battery_present_pin_i = 1'b0;
            1: adapter_valid_flag_i = 1'b0;
            2: register_reset_i = 1'b1;
            3: target_voltage_zero_i = 1'b1;
            default: watchdog_expire_i = 1'b1;
        endcase
        w(1);
        {register_reset_i, target_voltage_zero_i, watchdog_expire_i} = 3'b000;
        w(3);
        {battery_present_pin_i, adapter_valid_flag_i} = 2'b11;
        w(1);
    endtask
    // One-cycle comparator trip followed by a quiet spell
    task automatic trip();
        w(1);
        comparator_trip_i = 1'b1;
        w(1);
        comparator_trip_i = 1'b0;
        w(3);
    endtask
    initial begin
        {reset_n_i, comparator_trip_i, status_read_i, register_reset_i} = 4'h0;
        {target_voltage_zero_i, watchdog_expire_i, auto_input_regulation_off_i} = 3'h0;
        {battery_present_pin_i, adapter_valid_flag_i, comparator_processor_hot_signal_enable_i} = 3'h7;
        sense_resistor_large_i = 1'b0;
        w(10);
        reset_n_i = 1'b1;
        w(1);
        u_chg_host_model.rd(8'h00, 1, v);
        chk(v, 16'h000E);
        u_chg_host_model.rd(8'h02, 2, v);
        chk(v, 16'h0000);
        $display("test defaults done");
        foreach (pat[i]) begin
            u_chg_host_model.wr(8'h00, {8'h00, pat[i]}, 1);
            chk(16'(ob), 16'(pat[i][6:0]));
            chk(16'(battery_switch_full_on_o), {15'h0000, ~pat[i][2]});
        end
        $display("test option done");
        u_chg_host_model.wr(8'h00, 16'h000E, 1);
        u_chg_host_model.wr(8'h02, 16'h1FFF, 2);
        u_chg_host_model.rd(8'h02, 2, v);
        chk(v, 16'h1FC0);
        chk(16'(charge_current_ma_o), 16'h3F80);
        chk(16'(charge_enable_o), 16'h0001);
        sense_resistor_large_i = 1'b1;
        w(3);
        chk(16'(charge_current_ma_o), 16'h1FC0);
        u_chg_host_model.wr(8'h02, 16'h2040, 2);
        chk(charging_amperage_target_o, 16'h1FC0);
        u_chg_host_model.wr(8'h02, 16'h0105, 2);
        chk(16'(charge_current_ma_o), 16'h0100);
        u_chg_host_model.wr(8'h00, 16'h000F, 1);
        chk(16'(charge_enable_o), 16'h0000);
        $display("test setpoint done");
        auto_input_regulation_off_i = 1'b1;
        for (int k = 0; k < 5; k++) begin
            u_chg_host_model.wr(8'h00, 16'h0052, 1);
            u_chg_host_model.wr(8'h02, 16'h0240, 2);
            chk(charging_amperage_target_o, 16'h0240);
            ev(k);
            chk(charging_amperage_target_o, 16'h0000);
            if (k == 0) chk(16'(input_regulation_enable_o), 16'h0000);
            if (k == 2) chk(16'(ob), 16'h000E);
        end
        $display("test events done");
        u_chg_host_model.dev = 7'h2B;
        u_chg_host_model.wr(8'h02, 16'h00C0, 2);
        chk(16'(u_chg_host_model.addr_ack), 16'h0000);
        chk(charging_amperage_target_o, 16'h0000);
        u_chg_host_model.dev = `CHG_DEV_ADDR;
        u_chg_host_model.wr(8'h00, 16'h008E, 1);
        trip();
        chk({comparator_output_pin_o, comparator_status_o}, 16'h0001);
        status_read_i = 1'b1;
        w(1);
        status_read_i = 1'b0;
        w(2);
        chk({comparator_output_pin_o, comparator_status_o}, 16'h0000);
        u_chg_host_model.wr(8'h00, 16'h000E, 1);
        chk(16'(comparator_output_pin_o), 16'h0001);
        trip();
        chk({comparator_output_pin_o, comparator_status_o}, 16'h0002);
        $display("test comparator done");
        summarize();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        $display("CHECK FAILED t=%0t timeout", $time);
        summarize();
    end
endmodule
`default_nettype wire
